// >>> rtl/sacc_map.vh
`ifndef SACC_MAP_VH
`define SACC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SACC_OFS_CTRL 4'h0
`define SACC_OFS_RESULT 4'h1
`define SACC_OFS_CMPVAL 4'h2
`define SACC_OFS_STATUS 4'h3
`define SACC_OFS_IRQSEL 4'h4
`define SACC_OFS_CMD 4'h5
`define SACC_OFS_RESULT_LO 4'h7
// ----------------------------------------
// Fields
// ----------------------------------------
`define SACC_CTRL_MODE_BIT 3
`define SACC_IRQSEL_BIT 2
`define SACC_CMD_START_BIT 0
`define SACC_CMD_SKIP_BIT 1
`define SACC_CMD_IACK_BIT 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SACC_CTRL_RST 4'h0
`define SACC_IRQSEL_RST 4'h0
`define SACC_RESULT_RST 10'h000
`define SACC_CMPVAL_RST 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define SACC_MCYC_CLKS 8'h04
`define SACC_CONV_MCYC 7'h3E
`define SACC_CMP_MCYC 7'h08
`define SACC_STEP_MCYC 7'h06
`endif

// >>> rtl/sacc_top.v
// Operation
// RL1: 10-bit result held; high transfer returns upper 8 bits as B and A.
// RL2: Low transfer puts result bits 1:0 in A[3:2], A[1:0] zero.
// RL3: CPU must not transfer results during a conversion.
// RL4: During conversion DAC code is the current 10-bit result value.
// RL5: Conversion mode sets done flag at finish; skip test reads it.
// RL6: Done flag clears on interrupt taken or on a successful skip.
// RL7: Interrupt-select bit picks interrupt or skip service of done flag.
// RL8: Start begins conversion; result stored automatically at completion.
// RL9: Control bit 3 set selects comparator mode.
// RL10: Result cleared at start, bits tried MSB to LSB, kept if ref below input.
// RL11: Conversion completes 62 machine cycles after start; flag and irq then.
// RL12: Comparator value 8 bits, load writes B high nibble, A low nibble.
// RL13: Result undefined entering comparator mode; comparator value retained.
// RL14: Comparator value accessible only in comparator mode.
// RL15: In comparator mode DAC code is the 8-bit comparator value.
// RL16: Comparator mode done flag set when input below reference.
// RL17: Comparison ends 8 machine cycles after start, outcome into flag.
// RL18: Software must not change mode during an operation.
// RL19: Clear interrupt select before leaving comparator mode.
// RL20: Run one skip test after returning to conversion mode.
// RL21: Analog pins stay on port logic; software drives outputs high.
// RL22: Control bit 3 zero selects conversion mode.
// RL23: Control bits 1:0 select analog channel zero to three.
// RL24: Control register resets to zero: conversion mode, channel zero.
// RL25: Ten decisions evenly spaced, one comparator sample each, one bit each.
// RL26: Busy held from start to end; mux uses channel latched at start.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_top (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire [3:0] addr_in,
    input wire [9:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [9:0] rdata_out,
    input wire cmp_below_in,
    output reg [9:0] dac_code_out,
    output reg dac_fine_out,
    output reg [1:0] mux_sel_out,
    output reg busy_out,
    output wire done_flag_out,
    output wire irq_req_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_CMP = 2'h2;

    reg [3:0] converter_control_reg;
    reg [3:0] irq_control_reg_two;
    reg [9:0] result;
    reg [7:0] cmp_value;
    reg done_flag;
    reg skip_taken;
    reg [1:0] state;
    reg [7:0] div_cnt;
    reg [6:0] mcyc_cnt;
    reg [6:0] step_cnt;
    reg [3:0] bit_idx;
    reg [9:0] next_result;
    reg done_set;
    reg [9:0] next_rdata;
    wire mcyc_tick;
    wire wr_ctrl;
    wire wr_cmd;
    wire cmp_mode;
    wire irq_sel;
    wire start_req;
    wire skip_req;
    wire iack_req;
    wire done_clr;
    wire start_convert_op;
    wire done_skip_test_op;
    wire compare_value_load_op;
    wire result_high_transfer_op;
    wire result_low_transfer_op;
    wire step_end;
    wire sar_decide;
    wire conv_end;
    wire cmp_end;

    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    assign mcyc_tick = (div_cnt == (`SACC_MCYC_CLKS - 8'h01));
    assign wr_ctrl = wr_in && (addr_in == `SACC_OFS_CTRL);
    assign wr_cmd = wr_in && (addr_in == `SACC_OFS_CMD);
    assign start_convert_op = wr_cmd && wdata_in[`SACC_CMD_START_BIT];
    assign done_skip_test_op = wr_cmd && wdata_in[`SACC_CMD_SKIP_BIT];
    // Refused outside comparator mode, so the stored value survives mode swaps
    assign compare_value_load_op = wr_in && (addr_in == `SACC_OFS_CMPVAL) && cmp_mode; // RL14
    assign result_high_transfer_op = rd_in && (addr_in == `SACC_OFS_RESULT);
    assign result_low_transfer_op = rd_in && (addr_in == `SACC_OFS_RESULT_LO);
    assign cmp_mode = converter_control_reg[`SACC_CTRL_MODE_BIT]; // RL9 RL22
    assign irq_sel = irq_control_reg_two[`SACC_IRQSEL_BIT];
    // Start while busy is dropped rather than restarting the sequence
    assign start_req = start_convert_op && (state == ST_IDLE);
    assign skip_req = done_skip_test_op && !irq_sel; // RL7
    assign iack_req = wr_cmd && wdata_in[`SACC_CMD_IACK_BIT] && irq_sel; // RL7
    assign done_clr = (skip_req && done_flag) || iack_req; // RL6
    assign done_flag_out = done_flag;
    assign irq_req_out = done_flag && irq_sel; // RL11

    assign step_end = mcyc_tick && (step_cnt == (`SACC_STEP_MCYC - 7'h01));
    assign sar_decide = (state == ST_CONV) && step_end && (bit_idx != 4'hF); // RL25
    assign conv_end = (state == ST_CONV) && mcyc_tick
        && (mcyc_cnt == (`SACC_CONV_MCYC - 7'h01)); // RL11
    assign cmp_end = (state == ST_CMP) && mcyc_tick
        && (mcyc_cnt == (`SACC_CMP_MCYC - 7'h01)); // RL17

    // ----------------------------------------
    // Machine cycle divider
    // ----------------------------------------
    // Free-running, so the start phase adds up to one machine cycle of slack
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            div_cnt <= 8'h00;
        end else if (mcyc_tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            converter_control_reg <= `SACC_CTRL_RST; // RL24
            irq_control_reg_two <= `SACC_IRQSEL_RST;
            cmp_value <= `SACC_CMPVAL_RST;
        end else begin
            if (wr_ctrl) begin
                converter_control_reg <= wdata_in[3:0];
            end
            // Bit 2 picks interrupt over skip service of the flag
            if (wr_in && addr_in == `SACC_OFS_IRQSEL) begin
                irq_control_reg_two <= wdata_in[3:0];
            end
            // Load from B:A; no other path writes it
            if (compare_value_load_op) begin
                cmp_value <= wdata_in[7:0]; // RL12 RL13 RL14
            end
        end
    end

    // ----------------------------------------
    // Successive approximation sequencer
    // ----------------------------------------
    // Decisions every 6 machine cycles; bit 9-k tested in window k, last decision at 60, end at 62
    always @* begin
        next_result = result;
        if (sar_decide) begin
            // Input below the trial level: the trial bit is dropped
            if (cmp_below_in) begin
                next_result[bit_idx] = 1'b0; // RL10 RL25
            end
            if (bit_idx != 4'h0) begin
                next_result[bit_idx - 4'h1] = 1'b1; // RL10
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            result <= `SACC_RESULT_RST;
            mcyc_cnt <= 7'h00;
            step_cnt <= 7'h00;
            bit_idx <= 4'h9;
            mux_sel_out <= 2'h0;
            busy_out <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        mux_sel_out <= converter_control_reg[1:0]; // RL23 RL26
                        busy_out <= 1'b1; // RL26
                        mcyc_cnt <= 7'h00;
                        step_cnt <= 7'h00;
                        bit_idx <= 4'h9;
                        if (cmp_mode) begin
                            state <= ST_CMP; // RL17
                        end else begin
                            result <= 10'h200; // RL10 RL8
                            state <= ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    result <= next_result;
                    if (mcyc_tick) begin
                        mcyc_cnt <= mcyc_cnt + 7'h01;
                        if (step_cnt == (`SACC_STEP_MCYC - 7'h01)) begin
                            step_cnt <= 7'h00;
                            if (bit_idx != 4'hF) begin
                                bit_idx <= bit_idx - 4'h1;
                            end
                        end else begin
                            step_cnt <= step_cnt + 7'h01;
                        end
                        if (conv_end) begin
                            state <= ST_IDLE; // RL11
                            busy_out <= 1'b0;
                        end
                    end
                end
                ST_CMP: begin
                    if (mcyc_tick) begin
                        mcyc_cnt <= mcyc_cnt + 7'h01;
                        if (cmp_end) begin
                            state <= ST_IDLE; // RL17
                            busy_out <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Done flag
    // ----------------------------------------
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            skip_taken <= 1'b0;
        end else begin
            skip_taken <= skip_req && done_flag;
        end
    end

    always @* begin
        done_set = 1'b0;
        if (conv_end) begin
            done_set = 1'b1; // RL5 RL11
        end else if (cmp_end && cmp_below_in) begin
            done_set = 1'b1; // RL16 RL17
        end
    end

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            done_flag <= 1'b0;
        end else if (done_set) begin
            done_flag <= 1'b1;
        end else if (done_clr) begin
            done_flag <= 1'b0; // RL6
        end
    end

    // ----------------------------------------
    // DAC drive
    // ----------------------------------------
    // Registered copy follows the trial code by one clock, well before a decision
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            dac_code_out <= 10'h000;
            dac_fine_out <= 1'b1;
        end else if (cmp_mode) begin
            dac_code_out <= {cmp_value, 2'h0}; // RL15
            dac_fine_out <= 1'b0;
        end else begin
            dac_code_out <= (state == ST_CONV) ? next_result : result; // RL4
            dac_fine_out <= 1'b1;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always @* begin
        next_rdata = 10'h000;
        if (result_high_transfer_op) begin
            // High transfer: B in [7:4], A in [3:0]
            next_rdata = {2'h0, result[9:2]}; // RL1
        end else if (result_low_transfer_op) begin
            // Low transfer: A = {r1, r0, 0, 0}
            next_rdata = {6'h00, result[1:0], 2'h0}; // RL2
        end else if (rd_in) begin
            case (addr_in)
                `SACC_OFS_CTRL: next_rdata = {6'h00, converter_control_reg};
                `SACC_OFS_CMPVAL: next_rdata = cmp_mode ? {2'h0, cmp_value} : 10'h000; // RL14
                `SACC_OFS_STATUS: next_rdata = {7'h00, skip_taken, busy_out, done_flag};
                `SACC_OFS_IRQSEL: next_rdata = {6'h00, irq_control_reg_two};
                default: next_rdata = 10'h000;
            endcase
        end
    end

    // Read data stand for one cycle only, zero otherwise
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 10'h000;
        end else begin
            rdata_out <= next_rdata;
        end
    end
endmodule // sacc_top

// >>> test/sacc_ana_model.sv
`timescale 1ns/1ps
module sacc_ana_model (
    input wire [39:0] vin_in,
    input wire [1:0] mux_sel_in,
    input wire [9:0] dac_code_in,
    output wire cmp_below_out
);
// Analog pins keep their port latches high; their digital reads go unused
wire [9:0] vin_sel = vin_in[mux_sel_in * 10 +: 10];
// One 1024-step scale: coarse codes arrive as {n,2'b00}
assign cmp_below_out = vin_sel < dac_code_in;
endmodule // sacc_ana_model

// >>> test/sacc_top_asserts.sv
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_top_asserts (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire [3:0] addr_in,
    input wire [9:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [9:0] rdata_out,
    input wire [9:0] dac_code_out,
    input wire dac_fine_out,
    input wire [1:0] mux_sel_out,
    input wire busy_out,
    input wire done_flag_out,
    input wire irq_req_out
);
// ----
// Helpers
// ----
// Divider phase makes the window a few clocks loose
localparam int CONV_LO = 243;
localparam int CONV_HI = 250;
localparam int CMP_LO = 29;
localparam int CMP_HI = 34;
wire cmd_wr = wr_in && addr_in == `SACC_OFS_CMD;
reg [8:0] busy_len;
always @(posedge sys_clk_in) begin
    if (!rst_n_in) busy_len <= 9'h000;
    else if (busy_out) busy_len <= busy_len + 9'h001;
    else busy_len <= 9'h000;
end
reg irq_sel_m;
always @(posedge sys_clk_in) begin
    if (!rst_n_in) irq_sel_m <= 1'b0;
    else if (wr_in && addr_in == `SACC_OFS_IRQSEL) irq_sel_m <= wdata_in[`SACC_IRQSEL_BIT];
end
default clocking @(posedge sys_clk_in); endclocking
default disable iff (!rst_n_in);
sequence s_start_idle;
    cmd_wr && wdata_in[`SACC_CMD_START_BIT] && !busy_out;
endsequence
sequence s_busy_run;
    busy_out [*2];
endsequence
// ----
// Properties
// ----
a_start_busy: assert property (s_start_idle |=> s_busy_run)
    else $error("busy not raised by start");
a_clear_msb: assert property (s_start_idle ##1 dac_fine_out |-> ##[0:1] dac_code_out == 10'h200)
    else $error("first trial code wrong");
a_conv_len: assert property ($fell(busy_out) && dac_fine_out |->
    busy_len >= CONV_LO && busy_len <= CONV_HI)
    else $error("conversion length wrong");
a_cmp_len: assert property ($fell(busy_out) && !dac_fine_out |->
    busy_len >= CMP_LO && busy_len <= CMP_HI)
    else $error("comparison length wrong");
a_done_end: assert property ($fell(busy_out) && dac_fine_out |-> ##[0:1] done_flag_out)
    else $error("done not set at end");
a_irq_flag: assert property (irq_req_out == (done_flag_out && irq_sel_m))
    else $error("irq without done");
a_mux_hold: assert property (busy_out && $past(busy_out) |-> $stable(mux_sel_out))
    else $error("channel moved while busy");
a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 10'h000)
    else $error("read data outside slot");
a_skip_clear: assert property (cmd_wr && wdata_in[`SACC_CMD_SKIP_BIT] && done_flag_out
    && !irq_req_out && !busy_out |=> !done_flag_out)
    else $error("skip left done set");
a_dac_scale: assert property (!dac_fine_out |-> dac_code_out[1:0] == 2'b00)
    else $error("coarse code low bits set");
endmodule // sacc_top_asserts
bind sacc_top sacc_top_asserts i_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .dac_code_out(dac_code_out), .dac_fine_out(dac_fine_out),
    .mux_sel_out(mux_sel_out), .busy_out(busy_out), .done_flag_out(done_flag_out),
    .irq_req_out(irq_req_out));

// >>> test/sacc_top_tb_top.sv
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_top_tb_top;
reg sys_clk_in = 0;
reg rst_n_in = 0;
reg [3:0] addr_in = 0;
reg [9:0] wdata_in = 0;
reg wr_in = 0;
reg rd_in = 0;
reg rd_d = 0;
reg [39:0] analog_input_level = 0;
reg [9:0] v;
reg [7:0] cv;
reg [9:0] exp_q[$];
integer bad_count = 0, checks = 0, seed = 32'h5064A36B, i;
wire [9:0] rdata_out, dac_code_out;
wire [1:0] mux_sel_out;
wire dac_fine_out, busy_out, done_flag_out, irq_req_out, cmp_below;
always #2 sys_clk_in = ~sys_clk_in;
sacc_top i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .cmp_below_in(cmp_below), .dac_code_out(dac_code_out), .dac_fine_out(dac_fine_out),
    .mux_sel_out(mux_sel_out), .busy_out(busy_out), .done_flag_out(done_flag_out),
    .irq_req_out(irq_req_out));
sacc_ana_model i_ana (.vin_in(analog_input_level), .mux_sel_in(mux_sel_out), .dac_code_in(dac_code_out),
    .cmp_below_out(cmp_below));
// ----
// Tasks
// ----
task close_out;
    begin
        if (exp_q.size() != 0) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: reads left unanswered", $time);
        end
        $display("mismatches %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
task check(input [9:0] got, input [9:0] want);
    begin
        checks = checks + 1;
        if (got !== want) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    end
endtask
task wr(input [3:0] a, input [9:0] d);
    begin
        @(posedge sys_clk_in);
        addr_in <= a; wdata_in <= d; wr_in <= 1;
        @(posedge sys_clk_in);
        wr_in <= 0;
    end
endtask
task rd(input [3:0] a, input [9:0] e);
    begin
        @(posedge sys_clk_in);
        addr_in <= a; rd_in <= 1; exp_q.push_back(e);
        @(posedge sys_clk_in);
        rd_in <= 0;
    end
endtask
// Bounded: a stuck busy ends the run
task wait_idle;
    integer n;
    begin
        n = 0;
        @(posedge sys_clk_in);
        while (busy_out !== 1'b0 && n < 400) begin
            @(posedge sys_clk_in);
            n = n + 1;
        end
        if (n >= 400) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: busy stuck", $time);
            close_out;
        end
        @(posedge sys_clk_in);
    end
endtask
always @(posedge sys_clk_in) begin
    rd_d <= rd_in;
    if (rd_d && exp_q.size() > 0) check(rdata_out, exp_q.pop_front());
end
// ----
// Sequence
// ----
initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1;
    #1 check(dac_fine_out, 1);
    rd(`SACC_OFS_CTRL, 0);
    rd(4'hF, 0);
    for (i = 0; i < 4; i = i + 1) begin
        v = (i == 0) ? 10'h000 : (i == 3) ? 10'h3FF : $random(seed);
        analog_input_level <= ({4{~v}} & ~(40'h3FF << (i * 10))) | ({30'h0, v} << (i * 10));
        wr(`SACC_OFS_CTRL, i);
        wr(`SACC_OFS_CMD, 1);
        #1 check(mux_sel_out, i);
        if (i == 1) wr(`SACC_OFS_CMD, 1);
        wait_idle;
        rd(`SACC_OFS_STATUS, 1);
        rd(`SACC_OFS_RESULT, v[9:2]);
        rd(4'h7, {v[1:0], 2'b00});
        wr(`SACC_OFS_CMD, 2);
        #1 check(done_flag_out, 0);
    end
    wr(`SACC_OFS_IRQSEL, 10'h004);
    wr(`SACC_OFS_CMD, 1);
    wait_idle;
    #1 check(irq_req_out, 1);
    wr(`SACC_OFS_CMD, 2);
    #1 check(done_flag_out, 1);
    wr(`SACC_OFS_CMD, 4);
    #1 check(done_flag_out, 0);
    wr(`SACC_OFS_IRQSEL, 0);
    wr(`SACC_OFS_CMPVAL, 10'h0AA);
    wr(`SACC_OFS_CTRL, 8);
    rd(`SACC_OFS_CMPVAL, 0);
    for (i = 0; i < 4; i = i + 1) begin
        cv = $random(seed) | 8'h01;
        wr(`SACC_OFS_CMPVAL, cv);
        rd(`SACC_OFS_CMPVAL, cv);
        #1 check(dac_code_out, {cv, 2'b00});
        v = {cv, 2'b00} - (i % 2 == 0);
        analog_input_level <= {4{v}};
        wr(`SACC_OFS_CMD, 1);
        wait_idle;
        #1 check(done_flag_out, i % 2 == 0);
        wr(`SACC_OFS_CMD, 2);
    end
    wr(`SACC_OFS_IRQSEL, 0);
    wr(`SACC_OFS_CTRL, 0);
    rd(`SACC_OFS_CMPVAL, 0);
    wr(`SACC_OFS_CMD, 2);
    #1 check(done_flag_out, 0);
    wr(`SACC_OFS_CTRL, 8);
    rd(`SACC_OFS_CMPVAL, cv);
    wr(`SACC_OFS_CTRL, 2);
    wr(`SACC_OFS_CMD, 1);
    rst_n_in <= 0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1;
    #1 check(busy_out, 0);
    check(dac_fine_out, 1);
    rd(`SACC_OFS_CTRL, 0);
    repeat (3) @(posedge sys_clk_in);
    close_out;
end
endmodule // sacc_top_tb_top
